//--- rtl/sysctl_params.svh
// Functional notes
// - call pushes return address, jumps, pointer plus two
// - jump loads counter with encoded target
// - return-immediate writes working register, then returns
// - return drops pointer by two, reloads counter
// - interrupt return returns and sets global enable
// - watchdog restart clears watchdog count
// - computed jump adds working register to counter
// - enable instruction sets global interrupt enable
// - disable instruction clears global interrupt enable
// - full halt stops all clocks and oscillators
// - core halt gates core clock, oscillators run
// - software reset acts like hardware reset
// - no system instruction alters arithmetic flags
// - jump, call, computed jump, returns take two cycles
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH
`define PC_RESET 13'h0000
`define SP_RESET 8'h00
`define SP_STEP 8'h02
`define WR_RESET 8'h00
`define RST_PULSE_CYCLES 4'h4
`define WDOG_RESET 16'h0000
`endif

//--- rtl/sysctl_pkg.sv
package sysctl_pkg;
	typedef enum logic [3:0] {
		OP_NOP, OP_CALL, OP_GOTO, OP_RETI_IMM, OP_RET, OP_RETI, OP_WDRESTART,
		OP_PCADD, OP_GIE_SET, OP_GIE_CLR, OP_HALT_SYS, OP_HALT_CPU, OP_SWRESET, OP_OTHER
	} op_t;
	typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_HALTED} state_t;
endpackage

//--- rtl/system_control_instructions.sv
`timescale 1ns/1ps
`include "sysctl_params.svh"
module system_control_instructions #(
	parameter int PC_W = 13,
	parameter int SP_W = 8,
	parameter int WD_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// decoded instruction from fetch
	input wire logic instr_valid,
	input wire sysctl_pkg::op_t instr_op,
	input wire logic [PC_W-1:0] instr_target,
	input wire logic [7:0] instr_imm,
	// stack memory read data (word at stack_top_pointer)
	input wire logic [PC_W-1:0] stack_rdata,
	// wake event for halts
	input wire logic wake,
	// flags from the rest of the core
	input wire logic [3:0] flags_in,
	// program counter and stack
	output logic [PC_W-1:0] pc,
	output logic [SP_W-1:0] stack_top_pointer,
	output logic stack_we,
	output logic [SP_W-1:0] stack_waddr,
	output logic [PC_W-1:0] stack_wdata,
	// working register
	output logic [7:0] working_register,
	// flags held unchanged
	output logic [3:0] flags,
	// interrupt, watchdog, clocks, reset
	output logic gie,
	output logic [WD_W-1:0] wdog_count,
	output logic core_clk_en,
	output logic osc_en,
	output logic chip_reset,
	// an instruction can be accepted this cycle
	output logic instr_ready
);
	sysctl_pkg::state_t state_reg, state_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [SP_W-1:0] sp_reg, sp_next;
	logic [7:0] wr_reg, wr_next;
	logic [3:0] flags_reg, flags_next;
	logic gie_reg, gie_next;
	logic set_gie_reg, set_gie_next;
	logic we_reg, we_next;
	logic [SP_W-1:0] waddr_reg, waddr_next;
	logic [PC_W-1:0] wdata_reg, wdata_next;
	logic cke_reg, cke_next;
	logic osc_reg, osc_next;
	logic [3:0] rcnt_reg, rcnt_next;
	logic rdy_reg, rdy_next;
	logic ret_pending_reg, ret_pending_next;
	logic wd_restart;
	logic sw_rst_reg;
	logic core_rst;

	// software reset folds into the core reset, same as the pin
	assign core_rst = rst | sw_rst_reg;

	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		sp_next = sp_reg;
		wr_next = wr_reg;
		flags_next = flags_in;
		gie_next = gie_reg;
		set_gie_next = 1'b0;
		we_next = 1'b0;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		cke_next = cke_reg;
		osc_next = osc_reg;
		rcnt_next = rcnt_reg;
		rdy_next = 1'b1;
		wd_restart = 1'b0;
		unique case (state_reg)
			sysctl_pkg::ST_EXEC: begin
				if (instr_valid && rdy_reg) begin
					unique case (instr_op)
						sysctl_pkg::OP_CALL: begin
							we_next = 1'b1;
							waddr_next = sp_reg;
							wdata_next = pc_reg + PC_W'(1);
							pc_next = instr_target;
							sp_next = sp_reg + SP_W'(`SP_STEP);
							state_next = sysctl_pkg::ST_SECOND;
							rdy_next = 1'b0;
						end
						sysctl_pkg::OP_GOTO: begin
							pc_next = instr_target;
							state_next = sysctl_pkg::ST_SECOND;
							rdy_next = 1'b0;
						end
						sysctl_pkg::OP_RETI_IMM, sysctl_pkg::OP_RET, sysctl_pkg::OP_RETI: begin
							if (instr_op == sysctl_pkg::OP_RETI_IMM) begin
								wr_next = instr_imm;
							end
							sp_next = sp_reg - SP_W'(`SP_STEP);
							set_gie_next = (instr_op == sysctl_pkg::OP_RETI);
							state_next = sysctl_pkg::ST_SECOND;
							rdy_next = 1'b0;
						end
						sysctl_pkg::OP_PCADD: begin
							pc_next = pc_reg + PC_W'(wr_reg);
							state_next = sysctl_pkg::ST_SECOND;
							rdy_next = 1'b0;
						end
						sysctl_pkg::OP_WDRESTART: begin
							wd_restart = 1'b1;
							pc_next = pc_reg + PC_W'(1);
						end
						sysctl_pkg::OP_GIE_SET: begin
							gie_next = 1'b1;
							pc_next = pc_reg + PC_W'(1);
						end
						sysctl_pkg::OP_GIE_CLR: begin
							gie_next = 1'b0;
							pc_next = pc_reg + PC_W'(1);
						end
						sysctl_pkg::OP_HALT_SYS: begin
							cke_next = 1'b0;
							osc_next = 1'b0;
							pc_next = pc_reg + PC_W'(1);
							state_next = sysctl_pkg::ST_HALTED;
							rdy_next = 1'b0;
						end
						sysctl_pkg::OP_HALT_CPU: begin
							cke_next = 1'b0;
							osc_next = 1'b1;
							pc_next = pc_reg + PC_W'(1);
							state_next = sysctl_pkg::ST_HALTED;
							rdy_next = 1'b0;
						end
						sysctl_pkg::OP_SWRESET: begin
							rcnt_next = `RST_PULSE_CYCLES;
							rdy_next = 1'b0;
						end
						sysctl_pkg::OP_NOP, sysctl_pkg::OP_OTHER: begin
							pc_next = pc_reg + PC_W'(1);
						end
						default: begin
							pc_next = pc_reg + PC_W'(1);
						end
					endcase
				end
				if (rcnt_reg != 4'h0) begin
					rcnt_next = rcnt_reg - 4'h1;
					rdy_next = 1'b0;
				end
			end
			sysctl_pkg::ST_SECOND: begin
				// second cycle; returns reload counter from the popped slot
				if (ret_pending_reg) begin
					pc_next = stack_rdata;
				end
				if (set_gie_reg) begin
					gie_next = 1'b1;
				end
				rdy_next = 1'b1;
				state_next = sysctl_pkg::ST_EXEC;
			end
			sysctl_pkg::ST_HALTED: begin
				rdy_next = 1'b0;
				if (wake) begin
					cke_next = 1'b1;
					osc_next = 1'b1;
					state_next = sysctl_pkg::ST_EXEC;
					rdy_next = 1'b1;
				end
			end
		endcase
	end

	assign ret_pending_next = (state_reg == sysctl_pkg::ST_EXEC) && instr_valid && rdy_reg &&
		(instr_op == sysctl_pkg::OP_RET || instr_op == sysctl_pkg::OP_RETI ||
		instr_op == sysctl_pkg::OP_RETI_IMM);

	always_ff @(posedge clk or posedge core_rst) begin
		if (core_rst) begin
			state_reg <= sysctl_pkg::ST_EXEC;
			pc_reg <= PC_W'(`PC_RESET);
			sp_reg <= SP_W'(`SP_RESET);
			wr_reg <= `WR_RESET;
			flags_reg <= 4'h0;
			gie_reg <= 1'b0;
			set_gie_reg <= 1'b0;
			we_reg <= 1'b0;
			waddr_reg <= SP_W'(`SP_RESET);
			wdata_reg <= PC_W'(`PC_RESET);
			cke_reg <= 1'b1;
			osc_reg <= 1'b1;
			rdy_reg <= 1'b0;
			ret_pending_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			sp_reg <= sp_next;
			wr_reg <= wr_next;
			flags_reg <= flags_next;
			gie_reg <= gie_next;
			set_gie_reg <= set_gie_next;
			we_reg <= we_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			cke_reg <= cke_next;
			osc_reg <= osc_next;
			rdy_reg <= rdy_next;
			ret_pending_reg <= ret_pending_next;
		end
	end

	// reset pulse counter lives outside the core reset so it can release it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rcnt_reg <= 4'h0;
			sw_rst_reg <= 1'b0;
		end else begin
			rcnt_reg <= rcnt_next;
			sw_rst_reg <= (rcnt_next != 4'h0);
		end
	end

	logic [WD_W-1:0] wd_cnt;
	logic wd_restart_reg;
	always_ff @(posedge clk or posedge core_rst) begin
		if (core_rst) begin
			wd_restart_reg <= 1'b0;
		end else begin
			wd_restart_reg <= wd_restart;
		end
	end
	wdog_counter #(.WIDTH(WD_W)) u_wdog (
		.clk(clk),
		.rst(core_rst),
		.restart(wd_restart_reg),
		.run(osc_reg),
		.count(wd_cnt)
	);
	logic [WD_W-1:0] wd_out_reg;
	always_ff @(posedge clk or posedge core_rst) begin
		if (core_rst) begin
			wd_out_reg <= WD_W'(`WDOG_RESET);
		end else begin
			wd_out_reg <= wd_cnt;
		end
	end

	assign pc = pc_reg;
	assign stack_top_pointer = sp_reg;
	assign stack_we = we_reg;
	assign stack_waddr = waddr_reg;
	assign stack_wdata = wdata_reg;
	assign working_register = wr_reg;
	assign flags = flags_reg;
	assign gie = gie_reg;
	assign wdog_count = wd_out_reg;
	assign core_clk_en = cke_reg;
	assign osc_en = osc_reg;
	assign chip_reset = sw_rst_reg;
	assign instr_ready = rdy_reg;

	AST_CALL_SP: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_CALL) |=> (sp_reg == $past(sp_reg) + SP_W'(`SP_STEP))
		&& we_reg && pc_reg == $past(instr_target))
		else $error("call did not push and jump");
	AST_GOTO_PC: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_GOTO) |=> pc_reg == $past(instr_target))
		else $error("jump target not loaded");
	AST_RETIMM_WR: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_RETI_IMM) |=> wr_reg == $past(instr_imm))
		else $error("immediate not in working register");
	AST_RET_SP: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_RET) |=> sp_reg == $past(sp_reg) - SP_W'(`SP_STEP)
		##1 pc_reg == $past(stack_rdata))
		else $error("return did not pop");
	AST_RETI_GIE: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_RETI) |=> ##1 gie_reg)
		else $error("interrupt return left enable clear");
	AST_PCADD: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_PCADD) |=> pc_reg == $past(pc_reg) + PC_W'($past(wr_reg)))
		else $error("computed jump wrong");
	AST_GIE_CLR: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_GIE_CLR && !set_gie_reg) |=> !gie_reg)
		else $error("disable did not clear enable");
	AST_HALT_CPU: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_HALT_CPU) |=> !cke_reg && osc_reg)
		else $error("core halt clock state wrong");
	AST_TWO_CYCLE: assert property (@(posedge clk) disable iff (core_rst)
		(instr_valid && rdy_reg && state_reg == sysctl_pkg::ST_EXEC &&
		instr_op == sysctl_pkg::OP_GOTO) |=> !rdy_reg ##1 rdy_reg)
		else $error("branch not two cycles");
	COV_CALL: cover property (@(posedge clk) instr_valid && rdy_reg && instr_op == sysctl_pkg::OP_CALL);
	COV_RETI: cover property (@(posedge clk) instr_valid && rdy_reg && instr_op == sysctl_pkg::OP_RETI);
	COV_HALT: cover property (@(posedge clk) state_reg == sysctl_pkg::ST_HALTED ##1 wake);
endmodule // system_control_instructions

//--- rtl/wdog_counter.sv
`timescale 1ns/1ps
`include "sysctl_params.svh"
module wdog_counter #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic restart,
	input wire logic run,
	// count
	output logic [WIDTH-1:0] count
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	always_comb begin
		count_next = count_reg;
		if (restart) begin
			count_next = WIDTH'(`WDOG_RESET);
		end else if (run) begin
			count_next = count_reg + WIDTH'(1);
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= WIDTH'(`WDOG_RESET);
		end else begin
			count_reg <= count_next;
		end
	end
	assign count = count_reg;
endmodule // wdog_counter

//--- verif/system_control_instructions_tb_top.sv
`timescale 1ns/1ps
`include "sysctl_params.svh"
module system_control_instructions_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	sysctl_pkg::op_t instr_op = sysctl_pkg::OP_NOP;
	logic [12:0] instr_target = 13'h0000;
	logic [7:0] instr_imm = 8'h00;
	logic [12:0] stack_rdata;
	logic wake = 1'b0;
	logic [3:0] flags_in = 4'h0;
	logic [12:0] pc, stack_wdata;
	logic [7:0] stack_top_pointer, stack_waddr, working_register;
	logic stack_we, gie, core_clk_en, osc_en, chip_reset, instr_ready;
	logic [3:0] flags, fl_q;
	logic [15:0] wdog_count;
	logic [12:0] mem [256];
	logic [12:0] e_stk [256];
	logic [12:0] e_pc;
	logic [7:0] e_sp, e_wr;
	logic e_gie, pc_known, r1;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	int seed_v;
	sysctl_pkg::op_t ops [10] = '{sysctl_pkg::OP_NOP, sysctl_pkg::OP_CALL, sysctl_pkg::OP_GOTO,
		sysctl_pkg::OP_RETI_IMM, sysctl_pkg::OP_RET, sysctl_pkg::OP_RETI, sysctl_pkg::OP_WDRESTART,
		sysctl_pkg::OP_PCADD, sysctl_pkg::OP_GIE_SET, sysctl_pkg::OP_GIE_CLR};

	always #5 clk = ~clk;

	system_control_instructions system_control_instructions_inst (
		.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
		.instr_target(instr_target), .instr_imm(instr_imm), .stack_rdata(stack_rdata),
		.wake(wake), .flags_in(flags_in), .pc(pc), .stack_top_pointer(stack_top_pointer),
		.stack_we(stack_we), .stack_waddr(stack_waddr), .stack_wdata(stack_wdata),
		.working_register(working_register), .flags(flags), .gie(gie),
		.wdog_count(wdog_count), .core_clk_en(core_clk_en), .osc_en(osc_en),
		.chip_reset(chip_reset), .instr_ready(instr_ready)
	);

	// stack memory beside the core
	assign stack_rdata = mem[stack_top_pointer];
	always @(posedge clk) begin
		if (stack_we === 1'b1)
			mem[stack_waddr] <= stack_wdata;
		fl_q <= flags_in;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end
	always @(negedge clk) flags_in <= 4'($urandom);

	task final_report();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(string nm, logic [15:0] e, logic [15:0] s);
		samples_checked++;
		if (e !== s) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task wait_ready();
		int n;
		n = 0;
		while (instr_ready !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		if (instr_ready !== 1'b1) begin
			failures++;
			$display("[FAIL] instr_ready expected 1 seen %b", instr_ready);
		end
	endtask

	// drive one instruction, optionally wait until the next may be taken
	task issue(sysctl_pkg::op_t op, logic [12:0] t, logic [7:0] im, bit wt);
		wait_ready();
		instr_valid = 1'b1;
		instr_op = op;
		instr_target = t;
		instr_imm = im;
		@(negedge clk);
		instr_valid = 1'b0;
		instr_target = 13'($urandom);
		r1 = instr_ready;
		if (wt) begin
			@(negedge clk);
			wait_ready();
		end
	endtask

	task chk_state();
		if (pc_known)
			chk("pc", e_pc, pc);
		chk("stack_top_pointer", e_sp, stack_top_pointer);
		chk("working_register", e_wr, working_register);
		chk("gie", e_gie, gie);
		chk("flags", fl_q, flags);
	endtask

	task model_reset();
		e_pc = `PC_RESET;
		e_sp = `SP_RESET;
		e_wr = `WR_RESET;
		e_gie = 1'b0;
		pc_known = 1'b1;
	endtask

	task automatic do_op(sysctl_pkg::op_t op);
		logic [12:0] t;
		logic [7:0] im;
		bit tw;
		t = 13'($urandom);
		im = 8'($urandom);
		if (op inside {sysctl_pkg::OP_RET, sysctl_pkg::OP_RETI, sysctl_pkg::OP_RETI_IMM}
			&& e_sp < 8'h02)
			op = sysctl_pkg::OP_CALL;
		if (op == sysctl_pkg::OP_CALL && e_sp >= 8'hf0)
			op = sysctl_pkg::OP_RET;
		if (!pc_known && op inside {sysctl_pkg::OP_CALL, sysctl_pkg::OP_PCADD})
			do_op(sysctl_pkg::OP_GOTO);
		tw = op inside {sysctl_pkg::OP_CALL, sysctl_pkg::OP_GOTO, sysctl_pkg::OP_PCADD,
			sysctl_pkg::OP_RET, sysctl_pkg::OP_RETI, sysctl_pkg::OP_RETI_IMM};
		issue(op, t, im, 1'b1);
		chk("ready_gap", {15'h0000, !tw}, {15'h0000, r1});
		case (op)
			sysctl_pkg::OP_CALL: begin
				chk("push", e_pc + 13'h0001, mem[e_sp]);
				e_stk[e_sp] = e_pc + 13'h0001;
				e_pc = t;
				e_sp = e_sp + `SP_STEP;
			end
			sysctl_pkg::OP_GOTO: begin
				e_pc = t;
				pc_known = 1'b1;
			end
			sysctl_pkg::OP_RET, sysctl_pkg::OP_RETI, sysctl_pkg::OP_RETI_IMM: begin
				if (op == sysctl_pkg::OP_RETI_IMM)
					e_wr = im;
				if (op == sysctl_pkg::OP_RETI)
					e_gie = 1'b1;
				e_sp = e_sp - `SP_STEP;
				e_pc = e_stk[e_sp];
				pc_known = 1'b1;
			end
			sysctl_pkg::OP_PCADD: e_pc = e_pc + {5'h00, e_wr};
			sysctl_pkg::OP_GIE_SET: e_gie = 1'b1;
			sysctl_pkg::OP_GIE_CLR: e_gie = 1'b0;
			default: e_pc = e_pc + 13'h0001;
		endcase
		if (op inside {sysctl_pkg::OP_GIE_SET, sysctl_pkg::OP_GIE_CLR})
			e_pc = e_pc + 13'h0001;
		chk_state();
	endtask

	initial begin
		int n;
		seed_v = $urandom(22495);
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		model_reset();
		// corner cases: all-ones return immediate, widest computed jump, reti after disable
		do_op(sysctl_pkg::OP_GIE_CLR);
		do_op(sysctl_pkg::OP_CALL);
		issue(sysctl_pkg::OP_RETI_IMM, 13'h0000, 8'hff, 1'b1);
		e_wr = 8'hff;
		e_sp = e_sp - `SP_STEP;
		e_pc = e_stk[e_sp];
		chk_state();
		do_op(sysctl_pkg::OP_OTHER);
		do_op(sysctl_pkg::OP_PCADD);
		do_op(sysctl_pkg::OP_CALL);
		do_op(sysctl_pkg::OP_RETI);
		for (int i = 0; i < 300; i++)
			do_op(ops[$urandom_range(9, 0)]);
		// halts released by wake
		issue(sysctl_pkg::OP_HALT_CPU, 13'h0000, 8'h00, 1'b0);
		repeat (2) @(negedge clk);
		chk("core_clk_en", 16'h0000, core_clk_en);
		chk("osc_en", 16'h0001, osc_en);
		wake = 1'b1;
		@(negedge clk);
		wake = 1'b0;
		wait_ready();
		chk("core_clk_en", 16'h0001, core_clk_en);
		issue(sysctl_pkg::OP_HALT_SYS, 13'h0000, 8'h00, 1'b0);
		repeat (2) @(negedge clk);
		chk("osc_en", 16'h0000, osc_en);
		chk("core_clk_en", 16'h0000, core_clk_en);
		wake = 1'b1;
		@(negedge clk);
		wake = 1'b0;
		wait_ready();
		chk("osc_en", 16'h0001, osc_en);
		// watchdog restart after it has run a while
		repeat (10) @(negedge clk);
		chk("wdog_run", 16'h0001, {15'h0000, wdog_count >= 16'h0004});
		issue(sysctl_pkg::OP_WDRESTART, 13'h0000, 8'h00, 1'b1);
		@(negedge clk);
		chk("wdog_restart", 16'h0001, {15'h0000, wdog_count < 16'h0004});
		// software reset after state is disturbed; halts and watchdog restart moved the counter unmodelled
		pc_known = 1'b0;
		do_op(sysctl_pkg::OP_GIE_SET);
		do_op(sysctl_pkg::OP_CALL);
		issue(sysctl_pkg::OP_SWRESET, 13'h0000, 8'h00, 1'b0);
		n = 0;
		repeat (12) begin
			if (chip_reset === 1'b1)
				n++;
			@(negedge clk);
		end
		chk("reset_pulse", `RST_PULSE_CYCLES, n[15:0]);
		wait_ready();
		model_reset();
		chk_state();
		final_report();
	end
endmodule // system_control_instructions_tb_top
